/* File: rtl/sz_defs.svh */
// Purpose: constants of the serial port zero block
// Assumes: byte-wide special-function-register access
// Notes:   offsets, field positions, reset values, timing counts
`ifndef SZ_DEFS_SVH
`define SZ_DEFS_SVH

`define SZ_CTRL_ADDR      8'h98
`define SZ_BUF_ADDR       8'h99
`define SZ_CTRL_RESET     8'h00
`define SZ_BUF_RESET      8'h00
`define SZ_UNMAPPED_READ  8'h00

// control register field positions
`define SZ_MODE_HI_BIT    7
`define SZ_MODE_MID_BIT   6
`define SZ_MODE_LOW_BIT   5
`define SZ_RX_EN_BIT      4
`define SZ_TX_NINTH_BIT   3
`define SZ_RX_NINTH_BIT   2
`define SZ_TXC_BIT        1
`define SZ_RXC_BIT        0

// timing: peripheral clocks per bit, oversample ticks per bit, bits per frame
`define SZ_M0_SLOW_PCLK   8'h0c
`define SZ_M0_FAST_PCLK   8'h04
`define SZ_M2_SLOW_PCLK   8'h40
`define SZ_M2_FAST_PCLK   8'h20
`define SZ_OVERSAMPLE     8'h10
`define SZ_SAMPLE_POINT   8'h08
`define SZ_DATA_BITS      8'h08
`define SZ_FRAME_SHORT    8'h0a
`define SZ_FRAME_LONG     8'h0b

`endif

/* File: rtl/sz_pkg.sv */
// Purpose: types of the serial port zero block
// Assumes: nothing
// Notes:   state codes are one-hot
package sz_pkg;
   typedef logic [7:0] sz_byte_type;
   typedef enum logic [1:0] {
      SZ_TX_IDLE = 2'b01,
      SZ_TX_SEND = 2'b10
   } sz_tx_state_type;
   typedef enum logic [1:0] {
      SZ_RX_IDLE = 2'b01,
      SZ_RX_RECV = 2'b10
   } sz_rx_state_type;
   typedef enum logic [1:0] {
      SZ_SY_IDLE = 2'b01,
      SZ_SY_RUN  = 2'b10
   } sz_sy_state_type;
endpackage

/* File: rtl/sz_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk_in
// Notes:   level changes only when stages two and three agree
`timescale 1ns/10ps
module sz_sync (
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   input  wire logic pin_in,
   output logic      level_out
);
   logic stage1;
   logic stage2;
   logic stage3;
   logic next_level;

   always_comb begin
      next_level = level_out;
      if (stage2 == stage3) begin
         next_level = stage3;
      end
   end

   // line idles high, so reset to one
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stage1    <= 1'b1;
         stage2    <= 1'b1;
         stage3    <= 1'b1;
         level_out <= 1'b1;
      end else begin
         stage1    <= pin_in;
         stage2    <= stage1;
         stage3    <= stage2;
         level_out <= next_level;
      end
   end
endmodule // sz_sync

/* File: rtl/sz_tick.sv */
// Purpose: oversample tick for the asynchronous modes
// Assumes: timer ticks are one-cycle pulses on clk_in at 16x bit rate
// Notes:   no tick while the peripheral clock is stopped
`timescale 1ns/10ps
`include "sz_defs.svh"
module sz_tick (
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   input  wire logic run_in,
   input  wire logic mode_hi_in,
   input  wire logic mode_mid_in,
   input  wire logic mode_low_in,
   input  wire logic baud_double_in,
   input  wire logic timer1_tick_in,
   input  wire logic timer2_tick_in,
   input  wire logic timer2_select_in,
   output logic      tick_out
);
   import sz_pkg::*;
   logic [3:0] div_cnt;
   logic [3:0] next_div_cnt;
   logic [3:0] div_last;
   logic       next_tick;
   logic       use_t2;

   always_comb begin
      next_div_cnt = 4'h0;
      next_tick    = 1'b0;
      div_last     = baud_double_in ?
         4'(`SZ_M2_FAST_PCLK / `SZ_OVERSAMPLE - 8'h01) :
         4'(`SZ_M2_SLOW_PCLK / `SZ_OVERSAMPLE - 8'h01);
      use_t2 = timer2_select_in & ~(~mode_hi_in & mode_low_in);
      if (run_in) begin
         if (mode_hi_in && !mode_mid_in) begin
            if (div_cnt == div_last) begin
               next_tick = 1'b1;
            end else begin
               next_div_cnt = div_cnt + 4'h1;
            end
         end else if (mode_mid_in) begin
            next_tick = use_t2 ? timer2_tick_in : timer1_tick_in;
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div_cnt  <= 4'h0;
         tick_out <= 1'b0;
      end else begin
         div_cnt  <= next_div_cnt;
         tick_out <= next_tick;
      end
   end
endmodule // sz_tick

/* File: rtl/sz_uart.sv */
// Purpose: serial port zero, synchronous and asynchronous modes
// Assumes: byte register port on clk_in; idle_in stops the port
// Notes:   asynchronous modes sample 16 times per bit, LSB first
// Summary of operation
// - the upper two bits of the three-bit mode field select the mode; modes 1-3 frame data with one start and one stop bit.
// - mode 0 shifts 8 bits at 12 or 4 clocks per bit, mode 2 runs at 64 or 32 clocks per bit.
// - modes 1 and 3 time bits from timer 1 or 2 by a select input; mode 1 with valid stop uses timer 1.
// - the port only advances while the device is not idle.
// - mode 1 with the low mode bit set raises receive complete only on a valid stop bit.
// - modes 2 and 3 with multiprocessor set do not raise receive complete when the ninth bit is 0.
// - receive enable clear stops asynchronous reception, not a mode 0 receive; set enables it, and in mode 0 setting starts a receive.
// - modes 2 and 3 send the transmit ninth bit as the ninth data bit.
// - the receive ninth bit takes the ninth bit in modes 2 and 3 and the stop bit in mode 1.
// - transmit complete sets after the eighth bit in mode 0, after the last data bit otherwise.
// - receive complete sets after bit 8 in mode 0, the stop sample in mode 1, the ninth bit in 2 and 3.
// - one data address: writes load transmit, reads return the receive buffer.
`timescale 1ns/10ps
`include "sz_defs.svh"
module sz_uart (
   input  wire logic                clk_in,
   input  wire logic                arst_n_in,
   input  wire logic [7:0]          sfr_addr_in,
   input  wire logic                sfr_wr_in,
   input  wire logic                sfr_rd_in,
   input  wire sz_pkg::sz_byte_type sfr_wdata_in,
   output sz_pkg::sz_byte_type      sfr_rdata_out,
   input  wire logic                idle_in,
   input  wire logic                baud_double_in,
   input  wire logic                timer1_tick_in,
   input  wire logic                timer2_tick_in,
   input  wire logic                timer2_baud_select_in,
   input  wire logic                intr_enable_in,
   input  wire logic                rxd_in,
   output logic                     rxd_out,
   output logic                     rxd_oe_out,
   output logic                     txd_out,
   output logic                     intr_out
);
   import sz_pkg::*;

   sz_byte_type     ctrl, next_ctrl;
   sz_byte_type     rx_buf, next_rx_buf;
   sz_byte_type     next_rdata;
   sz_tx_state_type tx_state, next_tx_state;
   logic [10:0]     tx_shift, next_tx_shift;
   logic [3:0]      tx_bits, next_tx_bits;
   logic [3:0]      tx_os, next_tx_os;
   sz_rx_state_type rx_state, next_rx_state;
   sz_byte_type     rx_data, next_rx_data;
   logic [3:0]      rx_os, next_rx_os;
   logic [3:0]      rx_idx, next_rx_idx;
   logic            rx_prev, next_rx_prev;
   sz_sy_state_type sy_state, next_sy_state;
   logic            sy_dir_tx, next_sy_dir_tx;
   sz_byte_type     sy_shift, next_sy_shift;
   logic [2:0]      sy_cnt, next_sy_cnt;
   logic [3:0]      sy_ph, next_sy_ph;
   logic [3:0]      sy_last;
   logic [3:0]      sy_half;
   logic            next_txd;
   logic            next_rxd;
   logic            next_rxd_oe;
   logic            next_intr;
   logic            rxd_s;
   logic            sample_tick;
   logic            run;
   logic            wr_ctrl;
   logic            wr_buf;
   logic            busy;
   logic            is_m0;
   logic            nine;
   logic            ti_set;
   logic            ri_set;
   logic            rx_bit;

   sz_sync u_rxd_sync (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .pin_in    (rxd_in),
      .level_out (rxd_s)
   );

   sz_tick u_tick (
      .clk_in           (clk_in),
      .arst_n_in        (arst_n_in),
      .run_in           (run),
      .mode_hi_in       (ctrl[`SZ_MODE_HI_BIT]),
      .mode_mid_in      (ctrl[`SZ_MODE_MID_BIT]),
      .mode_low_in      (ctrl[`SZ_MODE_LOW_BIT]),
      .baud_double_in   (baud_double_in),
      .timer1_tick_in   (timer1_tick_in),
      .timer2_tick_in   (timer2_tick_in),
      .timer2_select_in (timer2_baud_select_in),
      .tick_out         (sample_tick)
   );

   always_comb begin
      run     = ~idle_in;
      wr_ctrl = sfr_wr_in && (sfr_addr_in == `SZ_CTRL_ADDR);
      wr_buf  = sfr_wr_in && (sfr_addr_in == `SZ_BUF_ADDR);
      is_m0   = ~ctrl[`SZ_MODE_HI_BIT] & ~ctrl[`SZ_MODE_MID_BIT];
      nine    = ctrl[`SZ_MODE_HI_BIT];
      busy    = (tx_state != SZ_TX_IDLE) || (sy_state != SZ_SY_IDLE);
      sy_last = ctrl[`SZ_MODE_LOW_BIT] ?
         4'(`SZ_M0_FAST_PCLK - 8'h01) : 4'(`SZ_M0_SLOW_PCLK - 8'h01);
      sy_half = 4'((sy_last + 4'h1) >> 1);
      rx_bit  = rxd_s;

      next_ctrl     = ctrl;
      next_rx_buf   = rx_buf;
      ti_set        = 1'b0;
      ri_set        = 1'b0;
      next_tx_state = tx_state;
      next_tx_shift = tx_shift;
      next_tx_bits  = tx_bits;
      next_tx_os    = tx_os;
      next_rx_state = rx_state;
      next_rx_data  = rx_data;
      next_rx_os    = rx_os;
      next_rx_idx   = rx_idx;
      next_rx_prev  = sample_tick ? rxd_s : rx_prev;
      next_sy_state = sy_state;
      next_sy_dir_tx = sy_dir_tx;
      next_sy_shift = sy_shift;
      next_sy_cnt   = sy_cnt;
      next_sy_ph    = sy_ph;
      if (wr_ctrl) begin
         next_ctrl = sfr_wdata_in;
      end

      // asynchronous transmitter
      case (tx_state)
         SZ_TX_IDLE: begin
            if (wr_buf && !busy && !is_m0) begin
               next_tx_state = SZ_TX_SEND;
               next_tx_os    = 4'h0;
               next_tx_shift = nine ?
                  {1'b1, ctrl[`SZ_TX_NINTH_BIT], sfr_wdata_in, 1'b0} :
                  {2'b11, sfr_wdata_in, 1'b0};
               next_tx_bits  = nine ? 4'(`SZ_FRAME_LONG) :
                                      4'(`SZ_FRAME_SHORT);
            end
         end
         SZ_TX_SEND: begin
            if (sample_tick) begin
               next_tx_os = tx_os + 4'h1;
               if (tx_os == 4'(`SZ_OVERSAMPLE - 8'h01)) begin
                  next_tx_shift = {1'b1, tx_shift[10:1]};
                  next_tx_bits  = tx_bits - 4'h1;
                  if (tx_bits == 4'h2) begin
                     ti_set = 1'b1;
                  end
                  if (tx_bits == 4'h1) begin
                     next_tx_state = SZ_TX_IDLE;
                  end
               end
            end
         end
         default: next_tx_state = SZ_TX_IDLE;
      endcase

      // mode zero shift engine, shared by both directions
      case (sy_state)
         SZ_SY_IDLE: begin
            next_sy_ph  = 4'h0;
            next_sy_cnt = 3'h0;
            if (wr_buf && !busy && is_m0) begin
               next_sy_state  = SZ_SY_RUN;
               next_sy_dir_tx = 1'b1;
               next_sy_shift  = sfr_wdata_in;
            end else if (wr_ctrl && !busy &&
                         !sfr_wdata_in[`SZ_MODE_HI_BIT] &&
                         !sfr_wdata_in[`SZ_MODE_MID_BIT] &&
                         sfr_wdata_in[`SZ_RX_EN_BIT] &&
                         !ctrl[`SZ_RX_EN_BIT]) begin
               // setting enable starts mode zero receive
               next_sy_state  = SZ_SY_RUN;
               next_sy_dir_tx = 1'b0;
            end
         end
         SZ_SY_RUN: begin
            if (run) begin
               next_sy_ph = sy_ph + 4'h1;
               if (sy_ph == sy_last) begin
                  next_sy_ph  = 4'h0;
                  next_sy_cnt = sy_cnt + 3'h1;
                  // rx_bit trails the pin by four clocks, so the level
                  // at the clock rise arrives here; too late at 4 clocks
                  if (sy_dir_tx) begin
                     next_sy_shift = {1'b1, sy_shift[7:1]};
                  end else begin
                     next_sy_shift = {rx_bit, sy_shift[7:1]};
                  end
                  if (sy_cnt == 3'h7) begin
                     next_sy_state = SZ_SY_IDLE;
                     if (sy_dir_tx) begin
                        ti_set = 1'b1;
                     end else begin
                        ri_set      = 1'b1;
                        next_rx_buf = next_sy_shift;
                     end
                  end
               end
            end
         end
         default: next_sy_state = SZ_SY_IDLE;
      endcase

      // asynchronous receiver
      case (rx_state)
         SZ_RX_IDLE: begin
            if (sample_tick && ctrl[`SZ_RX_EN_BIT] && !is_m0 &&
                rx_prev && !rxd_s) begin
               next_rx_state = SZ_RX_RECV;
               next_rx_os    = 4'h0;
               next_rx_idx   = 4'h0;
            end
         end
         SZ_RX_RECV: begin
            if (!ctrl[`SZ_RX_EN_BIT]) begin
               next_rx_state = SZ_RX_IDLE;
            end else if (sample_tick) begin
               next_rx_os = rx_os + 4'h1;
               if (rx_os == 4'(`SZ_SAMPLE_POINT - 8'h01)) begin
                  next_rx_idx = rx_idx + 4'h1;
                  if (rx_idx == 4'h0 && rx_bit) begin
                     // false start: glitch shorter than half a bit
                     next_rx_state = SZ_RX_IDLE;
                  end else if (rx_idx == 4'(`SZ_DATA_BITS + 8'h01)) begin
                     next_rx_state = SZ_RX_IDLE;
                     if (!ctrl[`SZ_MODE_LOW_BIT] || rx_bit) begin
                        ri_set      = 1'b1;
                        next_rx_buf = rx_data;
                        next_ctrl[`SZ_RX_NINTH_BIT] = rx_bit;
                     end
                  end else if (rx_idx != 4'h0) begin
                     next_rx_data = {rx_bit, rx_data[7:1]};
                  end
               end
            end
         end
         default: next_rx_state = SZ_RX_IDLE;
      endcase

      next_ctrl[`SZ_TXC_BIT] = next_ctrl[`SZ_TXC_BIT] | ti_set;
      next_ctrl[`SZ_RXC_BIT] = next_ctrl[`SZ_RXC_BIT] | ri_set;

      next_rdata = sfr_rdata_out;
      if (sfr_rd_in) begin
         if (sfr_addr_in == `SZ_CTRL_ADDR) begin
            next_rdata = ctrl;
         end else if (sfr_addr_in == `SZ_BUF_ADDR) begin
            next_rdata = rx_buf;
         end else begin
            next_rdata = `SZ_UNMAPPED_READ;
         end
      end

      if (is_m0) begin
         next_txd = (sy_state == SZ_SY_RUN) ? (sy_ph >= sy_half) : 1'b1;
      end else begin
         next_txd = (tx_state == SZ_TX_SEND) ? tx_shift[0] : 1'b1;
      end
      next_rxd    = sy_shift[0];
      next_rxd_oe = (sy_state == SZ_SY_RUN) && sy_dir_tx;
      next_intr = intr_enable_in &
                  (ctrl[`SZ_TXC_BIT] | ctrl[`SZ_RXC_BIT]);
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl          <= `SZ_CTRL_RESET;
         rx_buf        <= `SZ_BUF_RESET;
         sfr_rdata_out <= 8'h00;
         tx_state      <= SZ_TX_IDLE;
         tx_shift      <= 11'h7ff;
         tx_bits       <= 4'h0;
         tx_os         <= 4'h0;
         rx_state      <= SZ_RX_IDLE;
         rx_data       <= 8'h00;
         rx_os         <= 4'h0;
         rx_idx        <= 4'h0;
         rx_prev       <= 1'b1;
         sy_state      <= SZ_SY_IDLE;
         sy_dir_tx     <= 1'b0;
         sy_shift      <= 8'hff;
         sy_cnt        <= 3'h0;
         sy_ph         <= 4'h0;
         txd_out       <= 1'b1;
         rxd_out       <= 1'b1;
         rxd_oe_out    <= 1'b0;
         intr_out      <= 1'b0;
      end else begin
         ctrl          <= next_ctrl;
         rx_buf        <= next_rx_buf;
         sfr_rdata_out <= next_rdata;
         tx_state      <= next_tx_state;
         tx_shift      <= next_tx_shift;
         tx_bits       <= next_tx_bits;
         tx_os         <= next_tx_os;
         rx_state      <= next_rx_state;
         rx_data       <= next_rx_data;
         rx_os         <= next_rx_os;
         rx_idx        <= next_rx_idx;
         rx_prev       <= next_rx_prev;
         sy_state      <= next_sy_state;
         sy_dir_tx     <= next_sy_dir_tx;
         sy_shift      <= next_sy_shift;
         sy_cnt        <= next_sy_cnt;
         sy_ph         <= next_sy_ph;
         txd_out       <= next_txd;
         rxd_out       <= next_rxd;
         rxd_oe_out    <= next_rxd_oe;
         intr_out      <= next_intr;
      end
   end
endmodule // sz_uart

/* File: test/sz_uart_sva.sv */
// Purpose: pin-level checks of the serial port zero block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   the flags are internal, so the checks lean on the pins
`timescale 1ns/10ps
module sz_uart_sva (
   input wire logic                clk_in,
   input wire logic                arst_n_in,
   input wire logic [7:0]          sfr_addr_in,
   input wire logic                sfr_wr_in,
   input wire logic                sfr_rd_in,
   input wire sz_pkg::sz_byte_type sfr_wdata_in,
   input wire sz_pkg::sz_byte_type sfr_rdata_out,
   input wire logic                idle_in,
   input wire logic                baud_double_in,
   input wire logic                timer1_tick_in,
   input wire logic                timer2_tick_in,
   input wire logic                timer2_baud_select_in,
   input wire logic                intr_enable_in,
   input wire logic                rxd_in,
   input wire logic                rxd_out,
   input wire logic                rxd_oe_out,
   input wire logic                txd_out,
   input wire logic                intr_out
);
   logic buf_wr;
   assign buf_wr = sfr_wr_in && sfr_addr_in == 8'h99;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   AST_UNMAPPED_READ: assert property (
      sfr_rd_in && sfr_addr_in != 8'h98 && sfr_addr_in != 8'h99
      |=> sfr_rdata_out == 8'h00)
      else $error("unmapped read returned data");
   AST_READ_HOLDS: assert property (
      !sfr_rd_in |=> $stable(sfr_rdata_out))
      else $error("read data moved without a read");
   AST_INTR_NEEDS_EN: assert property (
      intr_out |-> $past(intr_enable_in))
      else $error("interrupt raised while disabled");
   AST_INTR_OFF: assert property (
      !intr_enable_in |=> !intr_out)
      else $error("interrupt stayed up after disable");
   AST_FLAG_STAYS: assert property (
      intr_out && !sfr_wr_in && !$past(sfr_wr_in)
      ##1 intr_enable_in && !sfr_wr_in |=> intr_out)
      else $error("complete flag dropped by itself");
   // three cycles of slack for the tick pipeline
   AST_IDLE_FREEZE: assert property (
      (idle_in && !sfr_wr_in)[*3]
      |=> $stable(txd_out) && $stable(rxd_out))
      else $error("serial pins moved while idle");
   AST_OE_START: assert property (
      $rose(rxd_oe_out)
      |-> $past(buf_wr) || $past(buf_wr, 2) || $past(buf_wr, 3))
      else $error("data pin driven without a buffer write");
   AST_M0_DATA_HOLD: assert property (
      rxd_oe_out && $past(rxd_oe_out) && txd_out && $past(txd_out)
      |-> $stable(rxd_out))
      else $error("shift data moved while shift clock high");
   AST_M0_END_HIGH: assert property (
      $fell(rxd_oe_out) |-> txd_out)
      else $error("shift clock not high at end of shift");
   AST_PULSE_MIN: assert property (
      $changed(txd_out) |=> $stable(txd_out))
      else $error("transmit pin pulse shorter than two clocks");
endmodule // sz_uart_sva

bind sz_uart sz_uart_sva sz_uart_sva_i (.*);

/* File: test/sz_remote.sv */
// Purpose: remote serial device on the transmit and receive pins
// Assumes: caller enters each task just after a clock edge
// Notes:   bit time is given in clocks; the line idles high
`timescale 1ns/10ps
module sz_remote (
   input  wire logic clk_in,
   input  wire logic line_in,
   input  wire logic txd_in,
   output logic      drive_out
);
   initial drive_out = 1'b1;

   task automatic lvl(input logic l);
      for (int k = 0; k < 400 && txd_in !== l; k++) @(posedge clk_in);
   endtask

   task automatic send(input logic [10:0] f, input int n, input int bt);
      for (int i = 0; i < n; i++) begin
         drive_out <= f[i];
         repeat (bt) @(posedge clk_in);
      end
      drive_out <= 1'b1;
   endtask

   // sample mid-bit after the start edge
   task automatic recv(output logic [10:0] f, input int n, input int bt);
      f = 11'h000;
      for (int k = 0; k < 4000 && txd_in; k++) @(posedge clk_in);
      repeat (bt / 2) @(posedge clk_in);
      for (int i = 0; i < n; i++) begin
         f[i] = txd_in;
         repeat (bt) @(posedge clk_in);
      end
   endtask

   // shift clock rise marks valid data
   task automatic take0(output logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         lvl(1'b0);
         lvl(1'b1);
         d[i] = line_in;
      end
   endtask

   task automatic give0(input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         lvl(1'b0);
         drive_out <= d[i];
         lvl(1'b1);
      end
      repeat (6) @(posedge clk_in);
      drive_out <= 1'b1;
   endtask
endmodule // sz_remote

/* File: test/test_serial_port_zero_uart.sv */
// Purpose: self-checking bench of the serial port zero block
// Assumes: timer ticks every 2 and 4 clocks give 32 and 64 clock bits
// Notes:   the remote model sits on the serial pins
`timescale 1ns/10ps
module test_serial_port_zero_uart;
   import sz_pkg::*;
   logic        clk_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic [7:0]  sfr_addr_in = 8'h00;
   logic        sfr_wr_in = 1'b0;
   logic        sfr_rd_in = 1'b0;
   sz_byte_type sfr_wdata_in = 8'h00;
   sz_byte_type sfr_rdata_out;
   logic        idle_in = 1'b0;
   logic        baud_double_in = 1'b0;
   logic        timer1_tick_in = 1'b0;
   logic        timer2_tick_in = 1'b0;
   logic        timer2_baud_select_in = 1'b0;
   logic        intr_enable_in = 1'b0;
   logic        rxd_out, rxd_oe_out, txd_out, intr_out, drv;
   wire logic   rxd_in;
   logic [1:0]  tcnt = 2'h0;
   logic [10:0] fr;
   sz_byte_type v;
   int          error_cnt = 0, check_count = 0, cyc = 0;

   // the data pin is shared in mode 0
   assign rxd_in = rxd_oe_out ? rxd_out : drv;
   sz_uart sz_uart_i (.*);
   sz_remote sz_remote_i (.clk_in(clk_in), .line_in(rxd_in),
                          .txd_in(txd_out), .drive_out(drv));

   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      tcnt <= tcnt + 2'h1;
      timer1_tick_in <= tcnt[0];
      timer2_tick_in <= &tcnt;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input sz_byte_type d);
      @(posedge clk_in);
      sfr_addr_in <= a;
      sfr_wdata_in <= d;
      sfr_wr_in <= 1'b1;
      @(posedge clk_in);
      sfr_wr_in <= 1'b0;
   endtask
   task automatic ck(input logic [7:0] a, input sz_byte_type e);
      @(posedge clk_in);
      sfr_addr_in <= a;
      sfr_rd_in <= 1'b1;
      @(posedge clk_in);
      sfr_rd_in <= 1'b0;
      @(posedge clk_in);
      v = sfr_rdata_out;
      chk(11'(v), 11'(e));
   endtask

   task automatic t_reset();
      ck(8'h98, 8'h00);
      ck(8'h99, 8'h00);
      wr(8'h9a, 8'h5a);
      ck(8'h9a, 8'h00);
      ck(8'h98, 8'h00);
   endtask
   task automatic t_tx1();
      wr(8'h98, 8'h40);
      wr(8'h99, 8'ha5);
      sz_remote_i.recv(fr, 10, 32);
      chk(fr, 11'h34a);
      ck(8'h98, 8'h42);
      chk(11'(intr_out), 11'h0);
      intr_enable_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      chk(11'(intr_out), 11'h1);
      wr(8'h98, 8'h40);
      repeat (3) @(posedge clk_in);
      chk(11'(intr_out), 11'h0);
      intr_enable_in <= 1'b0;
   endtask
   task automatic t_tx3();
      timer2_baud_select_in <= 1'b1;
      wr(8'h98, 8'hc8);
      wr(8'h99, 8'h3c);
      sz_remote_i.recv(fr, 11, 64);
      chk(fr, 11'h678);
      ck(8'h98, 8'hca);
   endtask
   task automatic t_rx1();
      timer2_baud_select_in <= 1'b0;
      wr(8'h98, 8'h50);
      sz_remote_i.send(11'h32c, 10, 32);
      ck(8'h98, 8'h55);
      ck(8'h99, 8'h96);
   endtask
   // valid stop: timer 1 even with timer 2 selected
   task automatic t_rx_stop();
      timer2_baud_select_in <= 1'b1;
      wr(8'h98, 8'h70);
      sz_remote_i.send(11'h022, 10, 32);
      ck(8'h98, 8'h70);
      chk(11'(v & 8'hfb), 11'h070);
      sz_remote_i.send(11'h244, 10, 32);
      ck(8'h98, 8'h75);
      ck(8'h99, 8'h22);
   endtask
   task automatic t_rx_mp();
      wr(8'h98, 8'hf0);
      sz_remote_i.send(11'h4b4, 11, 64);
      ck(8'h98, 8'hf0);
      sz_remote_i.send(11'h702, 11, 64);
      ck(8'h98, 8'hf5);
      ck(8'h99, 8'h81);
   endtask
   task automatic t_rx_off();
      timer2_baud_select_in <= 1'b0;
      wr(8'h98, 8'h40);
      sz_remote_i.send(11'h2ee, 10, 32);
      ck(8'h98, 8'h40);
      ck(8'h99, 8'h81);
   endtask
   task automatic t_m2();
      baud_double_in <= 1'b1;
      wr(8'h98, 8'h80);
      wr(8'h99, 8'hc3);
      sz_remote_i.recv(fr, 11, 32);
      chk(fr, 11'h586);
      baud_double_in <= 1'b0;
      wr(8'h98, 8'h90);
      sz_remote_i.send(11'h61e, 11, 64);
      ck(8'h98, 8'h95);
      ck(8'h99, 8'h0f);
   endtask
   task automatic t_m0();
      logic [7:0] d;
      wr(8'h98, 8'h00);
      wr(8'h99, 8'h6b);
      sz_remote_i.take0(d);
      chk(11'(d), 11'h06b);
      repeat (8) @(posedge clk_in);
      ck(8'h98, 8'h02);
      wr(8'h98, 8'h20);
      wr(8'h99, 8'h94);
      sz_remote_i.take0(d);
      chk(11'(d), 11'h094);
      repeat (4) @(posedge clk_in);
      wr(8'h98, 8'h00);
      fork
         wr(8'h98, 8'h10);
         sz_remote_i.give0(8'h4d);
      join
      ck(8'h98, 8'h11);
      ck(8'h99, 8'h4d);
   endtask
   task automatic t_idle();
      logic moved;
      logic held;
      moved = 1'b0;
      wr(8'h98, 8'h40);
      wr(8'h99, 8'h5e);
      repeat (40) @(posedge clk_in);
      idle_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      held = txd_out;
      repeat (100) begin
         @(posedge clk_in);
         if (txd_out !== held)
            moved = 1'b1;
      end
      chk(11'(moved), 11'h0);
      ck(8'h98, 8'h40);
      idle_in <= 1'b0;
      repeat (400) @(posedge clk_in);
      ck(8'h98, 8'h42);
   endtask

   initial begin
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      t_reset();
      t_tx1();
      t_tx3();
      t_rx1();
      t_rx_stop();
      t_rx_mp();
      t_rx_off();
      t_m2();
      t_m0();
      t_idle();
      end_sim();
   end
endmodule // test_serial_port_zero_uart
